//--- hw/sau_pkg.sv
// Shared constants and types for the saturating add unit
package sau_pkg;
    // Widths and sizes
    localparam int unsigned DATA_W   = 32;
    localparam int unsigned ADDR_W   = 8;
    localparam int unsigned IDX_W    = 5;
    localparam int unsigned IMM_W    = 5;
    localparam int unsigned NUM_REGS = 32;
    localparam int unsigned MSB      = DATA_W - 1;

    // Clamp values for positive and negative saturation
    localparam logic [DATA_W-1:0] SAT_POS = 32'h7FFFFFFF;
    localparam logic [DATA_W-1:0] SAT_NEG = 32'h80000000;

    // Program status word field positions and reset value
    localparam int unsigned PSW_W   = 5;
    localparam int unsigned PSW_Z   = 0;
    localparam int unsigned PSW_S   = 1;
    localparam int unsigned PSW_OV  = 2;
    localparam int unsigned PSW_CY  = 3;
    localparam int unsigned PSW_SAT = 4;
    localparam logic [PSW_W-1:0] PSW_RST = 5'h00;

    // Interrupt status and mask layout
    localparam int unsigned IRQ_W      = 2;
    localparam int unsigned IRQ_SAT    = 0;
    localparam int unsigned IRQ_REFUSE = 1;
    localparam logic [IRQ_W-1:0] IRQ_RST = 2'h0;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_PSW      = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_IRQ_STS  = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 8'h08;
    localparam logic [ADDR_W-1:0] OFF_GPR_SEL  = 8'h0C;
    localparam logic [ADDR_W-1:0] OFF_GPR_DATA = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_OP_COUNT = 8'h14;

    // Bus response codes
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Operand forms of the saturating add
    typedef enum logic
    {
        SAU_FORM_REG = 1'b0,
        SAU_FORM_IMM = 1'b1
    } sau_form_e;
endpackage

//--- hw/sau_sat_adder.sv
// Combinational saturating 32-bit adder with flag outputs
`timescale 1ns/1ps
`default_nettype none

module sau_sat_adder
(
    input  wire logic [sau_pkg::DATA_W-1:0] augend,
    input  wire logic [sau_pkg::DATA_W-1:0] addend,
    output logic      [sau_pkg::DATA_W-1:0] sat_sum,
    output logic                            carry_out,
    output logic                            ovf,
    output logic                            neg,
    output logic                            zero
);
    import sau_pkg::*;

    logic [DATA_W:0]   wide_sum;
    logic [DATA_W-1:0] wrap_sum;

    // Unsigned sum keeps the carry in its top bit
    assign wide_sum = {1'b0, augend} + {1'b0, addend};
    assign wrap_sum = wide_sum[DATA_W-1:0];

    assign carry_out = wide_sum[DATA_W];

    assign ovf = (augend[MSB] == addend[MSB]) && (wrap_sum[MSB] != augend[MSB]);

    assign sat_sum = !ovf ? wrap_sum : (augend[MSB] ? SAT_NEG : SAT_POS);

    assign neg  = sat_sum[MSB];
    assign zero = (sat_sum == '0);
endmodule

`default_nettype wire

//--- hw/sau_top.sv
// Saturating add unit with register file, status word and bus slave
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Register form adds the source word to the destination word and writes the clamped sum to the destination.
// - Immediate form sign-extends a 5-bit field, adds it to the destination word and writes back the clamped sum.
// - A true sum above the largest positive word writes 7FFFFFFF instead of the wrapped value.
// - A true sum below the most negative word writes 80000000 instead of the wrapped value.
// - Carry is one when the add carries out of the top bit, else zero.
// - Overflow is one when the signed add overflows 32 bits, else zero.
// - Sign is the top bit of the clamped result.
// - Zero is one when the clamped result is all zeros.
// - Saturation flag is set on overflow and otherwise keeps its old value.
// - Saturation flag is sticky across later non-saturating adds.
// - An add runs normally whether or not the saturation flag is already set.
// - Only a software load of the status word can clear the saturation flag.
// - The source register keeps its contents unless it is also the destination; only destination and flags change.
module sau_top
(
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [sau_pkg::ADDR_W-1:0]  awaddr,
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [sau_pkg::DATA_W-1:0]  wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    output logic      [1:0]                  bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    input  wire logic [sau_pkg::ADDR_W-1:0]  araddr,
    input  wire logic                        arvalid,
    output logic                             arready,
    output logic      [sau_pkg::DATA_W-1:0]  rdata,
    output logic      [1:0]                  rresp,
    output logic                             rvalid,
    input  wire logic                        rready,
    input  wire logic                        instr_valid,
    output logic                             instr_ready,
    input  wire logic                        instr_imm_form,
    input  wire logic [sau_pkg::IDX_W-1:0]   first_source_operand,
    input  wire logic [sau_pkg::IDX_W-1:0]   destination_operand,
    input  wire logic [sau_pkg::IMM_W-1:0]   short_immediate_field,
    output logic      [sau_pkg::DATA_W-1:0]  result_data,
    output logic                             result_valid,
    output logic                             carry_flag,
    output logic                             overflow_flag,
    output logic                             sign_flag,
    output logic                             zero_flag,
    output logic                             sticky_saturation_flag,
    output logic                             irq
);
    import sau_pkg::*;

    // Register file contents seen by readers
    logic [DATA_W-1:0] gpr_word [NUM_REGS];

    // Operand path
    sau_form_e         form;
    logic [DATA_W-1:0] dst_val, src_val, imm_ext, addend, sat_sum;
    logic              add_carry, add_ovf, add_neg, add_zero;
    logic              exec_fire, refuse_evt;

    // Status word, interrupt and result state
    logic [PSW_W-1:0]  psw_reg, psw_next;
    logic [IRQ_W-1:0]  irq_sts_reg, irq_sts_next, irq_mask_reg;
    logic [IDX_W-1:0]  gpr_sel_reg;
    logic [DATA_W-1:0] op_count_reg, result_reg;
    logic              result_valid_reg;

    // Write and read channel state
    logic              aw_held_reg, w_held_reg, bvalid_reg, rvalid_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic [DATA_W-1:0] wdata_reg, rdata_reg;
    logic [3:0]        wstrb_reg;
    logic [1:0]        bresp_reg, rresp_reg;

    // Write and read decode
    logic              wr_go, wa_psw, wa_sts, wa_mask, wa_sel, wa_data;
    logic              wa_hit, psw_wr, gpr_wr, ar_take, ra_hit;
    logic [DATA_W-1:0] wmask, wr_old, merged, rd_mux;

    // Operand selection from the register file
    assign form    = sau_form_e'(instr_imm_form);
    assign dst_val = gpr_word[destination_operand];
    assign src_val = gpr_word[first_source_operand];
    assign imm_ext = {{(DATA_W-IMM_W){short_immediate_field[IMM_W-1]}},
                      short_immediate_field};
    assign addend  = (form == SAU_FORM_IMM) ? imm_ext : src_val;

    assign refuse_evt  = instr_valid && (destination_operand == '0);
    assign exec_fire   = instr_valid && (destination_operand != '0);
    assign instr_ready = 1'b1;

    // Saturating adder
    sau_sat_adder u_adder
    (
        .augend    (dst_val),
        .addend    (addend),
        .sat_sum   (sat_sum),
        .carry_out (add_carry),
        .ovf       (add_ovf),
        .neg       (add_neg),
        .zero      (add_zero)
    );

    // Register file entries; entry zero is hard-wired to zero
    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++)
        begin : g_gpr
            logic [DATA_W-1:0] entry_reg;
            logic              hit_exec;
            logic              hit_bus;
            assign hit_exec = exec_fire
                              && (destination_operand == IDX_W'(gi));
            assign hit_bus  = gpr_wr && (gpr_sel_reg == IDX_W'(gi));
            always_ff @(posedge aclk)
            begin
                if (!aresetn || gi == 0)
                    entry_reg <= '0;
                else if (hit_exec)
                    entry_reg <= sat_sum;
                else if (hit_bus)
                    entry_reg <= merged;
            end
            assign gpr_word[gi] = entry_reg;
        end
    endgenerate

    // Status word next value; bus writes never meet an add
    always_comb
    begin
        psw_next = psw_reg;
        if (exec_fire)
        begin
            psw_next[PSW_CY]  = add_carry;
            psw_next[PSW_OV]  = add_ovf;
            psw_next[PSW_S]   = add_neg;
            psw_next[PSW_Z]   = add_zero;
            psw_next[PSW_SAT] = psw_reg[PSW_SAT] | add_ovf;
        end
        else if (psw_wr)
        begin
            psw_next = merged[PSW_W-1:0];
        end
    end

    // Interrupt status: events set, write one clears, set wins
    assign irq_sts_next =
        (irq_sts_reg & ~((wr_go && wa_sts) ? merged[IRQ_W-1:0] : '0))
        | {refuse_evt, exec_fire && add_ovf};
    assign irq = |(irq_sts_reg & irq_mask_reg);

    // Core state registers
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            psw_reg          <= PSW_RST;
            irq_sts_reg      <= IRQ_RST;
            irq_mask_reg     <= IRQ_RST;
            gpr_sel_reg      <= '0;
            op_count_reg     <= '0;
            result_reg       <= '0;
            result_valid_reg <= 1'b0;
        end
        else
        begin
            psw_reg          <= psw_next;
            irq_sts_reg      <= irq_sts_next;
            result_valid_reg <= exec_fire;
            if (exec_fire)
            begin
                result_reg   <= sat_sum;
                op_count_reg <= op_count_reg + 1'b1;
            end
            if (wr_go && wa_mask)
                irq_mask_reg <= merged[IRQ_W-1:0];
            if (wr_go && wa_sel)
                gpr_sel_reg  <= merged[IDX_W-1:0];
        end
    end

    // Flag and result outputs
    assign carry_flag             = psw_reg[PSW_CY];
    assign overflow_flag          = psw_reg[PSW_OV];
    assign sign_flag              = psw_reg[PSW_S];
    assign zero_flag              = psw_reg[PSW_Z];
    assign sticky_saturation_flag = psw_reg[PSW_SAT];
    assign result_data            = result_reg;
    assign result_valid           = result_valid_reg;

    // Write decode; a pending add holds the bus write back
    assign wr_go   = aw_held_reg && w_held_reg && !bvalid_reg && !instr_valid;
    assign wa_psw  = (awaddr_reg == OFF_PSW);
    assign wa_sts  = (awaddr_reg == OFF_IRQ_STS);
    assign wa_mask = (awaddr_reg == OFF_IRQ_MASK);
    assign wa_sel  = (awaddr_reg == OFF_GPR_SEL);
    assign wa_data = (awaddr_reg == OFF_GPR_DATA);
    assign wa_hit  = wa_psw || wa_sts || wa_mask || wa_sel || wa_data;
    assign wmask   = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
                      {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    assign wr_old  = wa_psw  ? DATA_W'(psw_reg)      :
                     wa_mask ? DATA_W'(irq_mask_reg) :
                     wa_sel  ? DATA_W'(gpr_sel_reg)  :
                     wa_data ? gpr_word[gpr_sel_reg] : '0;
    assign merged  = (wr_old & ~wmask) | (wdata_reg & wmask);
    assign psw_wr  = wr_go && wa_psw;
    assign gpr_wr  = wr_go && wa_data;
    assign awready = !aw_held_reg && !bvalid_reg;
    assign wready  = !w_held_reg && !bvalid_reg;
    assign bvalid  = bvalid_reg;
    assign bresp   = bresp_reg;

    // Write address and data capture, response generation
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_reg <= 1'b0;
            awaddr_reg  <= '0;
            w_held_reg  <= 1'b0;
            wdata_reg   <= '0;
            wstrb_reg   <= '0;
            bvalid_reg  <= 1'b0;
            bresp_reg   <= RESP_OKAY;
        end
        else
        begin
            if (awvalid && awready)
            begin
                aw_held_reg <= 1'b1;
                awaddr_reg  <= awaddr;
            end
            if (wvalid && wready)
            begin
                w_held_reg <= 1'b1;
                wdata_reg  <= wdata;
                wstrb_reg  <= wstrb;
            end
            if (wr_go)
            begin
                aw_held_reg <= 1'b0;
                w_held_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= wa_hit ? RESP_OKAY : RESP_SLVERR;
            end
            else if (bvalid_reg && bready)
                bvalid_reg <= 1'b0;
        end
    end

    // Read decode; unmapped reads return zero with an error
    assign ar_take = arvalid && arready;
    assign ra_hit  = (araddr == OFF_PSW) || (araddr == OFF_IRQ_STS)
                     || (araddr == OFF_IRQ_MASK) || (araddr == OFF_GPR_SEL)
                     || (araddr == OFF_GPR_DATA)
                     || (araddr == OFF_OP_COUNT);
    assign rd_mux  =
        (araddr == OFF_PSW)      ? DATA_W'(psw_reg)      :
        (araddr == OFF_IRQ_STS)  ? DATA_W'(irq_sts_reg)  :
        (araddr == OFF_IRQ_MASK) ? DATA_W'(irq_mask_reg) :
        (araddr == OFF_GPR_SEL)  ? DATA_W'(gpr_sel_reg)  :
        (araddr == OFF_GPR_DATA) ? gpr_word[gpr_sel_reg] :
        (araddr == OFF_OP_COUNT) ? op_count_reg          : '0;
    assign arready = !rvalid_reg;
    assign rvalid  = rvalid_reg;
    assign rdata   = rdata_reg;
    assign rresp   = rresp_reg;

    // Read response register
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_reg <= 1'b0;
            rdata_reg  <= '0;
            rresp_reg  <= RESP_OKAY;
        end
        else if (ar_take)
        begin
            rvalid_reg <= 1'b1;
            rdata_reg  <= rd_mux;
            rresp_reg  <= ra_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (rvalid_reg && rready)
            rvalid_reg <= 1'b0;
    end

    // Checks on the add path and flags
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    AST_REG_SUM: assert property (
        exec_fire && form == SAU_FORM_REG && !add_ovf
        |=> result_data == $past(dst_val + src_val))
        else $error("register form sum wrong");

    AST_IMM_SUM: assert property (
        exec_fire && form == SAU_FORM_IMM && !add_ovf
        |=> result_data == $past(dst_val + imm_ext))
        else $error("immediate form sum wrong");

    AST_CLAMP_POS: assert property (
        exec_fire && add_ovf && !dst_val[MSB]
        |=> result_data == SAT_POS && !sign_flag)
        else $error("positive clamp missing");

    AST_CLAMP_NEG: assert property (
        exec_fire && add_ovf && dst_val[MSB]
        |=> result_data == SAT_NEG && sign_flag)
        else $error("negative clamp missing");

    AST_CARRY: assert property (
        exec_fire
        |=> carry_flag == $past(({1'b0, dst_val} + {1'b0, addend}) > SAT_NEG
                                 + SAT_POS))
        else $error("carry flag wrong");

    AST_OVF: assert property (
        exec_fire
        |=> overflow_flag == $past(dst_val[MSB] == addend[MSB]
                                   && (dst_val + addend) >> MSB
                                      != DATA_W'(dst_val[MSB])))
        else $error("overflow flag wrong");

    AST_SIGN_ZERO: assert property (
        result_valid
        |-> sign_flag == result_data[MSB]
            && zero_flag == (result_data == '0))
        else $error("sign or zero flag wrong");

    AST_SAT_SET: assert property (
        exec_fire && add_ovf |=> sticky_saturation_flag [*1] ##1 1'b1)
        else $error("saturation flag not set");

    AST_SAT_STICKY: assert property (
        sticky_saturation_flag && !psw_wr |=> sticky_saturation_flag)
        else $error("saturation flag lost");

    AST_SAT_CLEAR: assert property (
        $fell(sticky_saturation_flag) |-> $past(psw_wr))
        else $error("saturation flag cleared without load");

    AST_SRC_KEEP: assert property (
        exec_fire && first_source_operand != destination_operand
        |=> gpr_word[$past(first_source_operand)] == $past(src_val))
        else $error("source register changed");

    AST_WRITEBACK: assert property (
        exec_fire |=> gpr_word[$past(destination_operand)] == result_data
                      && result_valid)
        else $error("destination not written");
endmodule

`default_nettype wire

//--- test/sau_dec_model.sv
// Decoder model that offers saturating adds to the unit
`timescale 1ns/1ps
`default_nettype none

module sau_dec_model
(
    input  wire logic                      aclk,
    input  wire logic                      aresetn,
    input  wire logic                      go,
    input  wire logic                      form,
    input  wire logic [sau_pkg::IDX_W-1:0] src,
    input  wire logic [sau_pkg::IDX_W-1:0] dst,
    input  wire logic [sau_pkg::IMM_W-1:0] imm,
    output logic                           instr_valid,
    output logic                           instr_imm_form,
    output logic      [sau_pkg::IDX_W-1:0] first_source_operand,
    output logic      [sau_pkg::IDX_W-1:0] destination_operand,
    output logic      [sau_pkg::IMM_W-1:0] short_immediate_field
);
    import sau_pkg::*;

    // zero destination only on command
    // One op per cycle; idle operand lines toggle so nothing stale is read
    always_ff @(posedge aclk)
    begin
        instr_valid           <= aresetn & go;
        instr_imm_form        <= aresetn & (go ? form : ~instr_imm_form);
        first_source_operand  <= go ? src : ~first_source_operand;
        destination_operand   <= go ? dst : ~destination_operand;
        short_immediate_field <= go ? imm : ~short_immediate_field;
    end
endmodule

`default_nettype wire

//--- test/test_sau_top.sv
// Self-checking bench for the saturating add unit
`timescale 1ns/1ps
`default_nettype none

module test_sau_top;
    import sau_pkg::*;
    logic              aclk, aresetn, awvalid, awready, wvalid, wready;
    logic              bvalid, arvalid, arready, rvalid, go, form, irq;
    logic              instr_valid, instr_ready, instr_imm_form, sat_exp;
    logic              result_valid, carry_flag, overflow_flag, sign_flag;
    logic              zero_flag, sticky_saturation_flag;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic [DATA_W-1:0] wdata, rdata, result_data;
    logic [1:0]        bresp, rresp, sts_exp, mask;
    logic [4:0]        first_source_operand, destination_operand, src, dst;
    logic [4:0]        short_immediate_field, imm, flg;
    logic [DATA_W-1:0] gpr [NUM_REGS];
    logic [36:0]       exp_q [$];
    logic [36:0]       e;
    int                n_errors, cmp_count, cycles, n_ops;
    integer            seed;
    localparam logic [31:0] VA [4] = '{32'h7FFFFFFF, 32'h80000000,
                                       32'h00000005, 32'h00000001};
    localparam logic [31:0] VB [4] = '{32'h00000001, 32'hFFFFFFFF,
                                       32'hFFFFFFFB, 32'h00000002};

    // Unit under test; response channels always accept
    sau_top i_sau_top
    (
        .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1),
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
        .rready(1'b1), .instr_valid, .instr_ready, .instr_imm_form,
        .first_source_operand, .destination_operand, .short_immediate_field,
        .result_data, .result_valid, .carry_flag, .overflow_flag,
        .sign_flag, .zero_flag, .sticky_saturation_flag, .irq
    );

    sau_dec_model i_sau_dec_model
    (
        .aclk, .aresetn, .go, .form, .src, .dst, .imm, .instr_valid,
        .instr_imm_form, .first_source_operand, .destination_operand,
        .short_immediate_field
    );

    assign flg = {carry_flag, overflow_flag, sign_flag, zero_flag,
                  sticky_saturation_flag};

    // Clock at 25 MHz
    initial
    begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic end_sim();
        $display("Errors %0d, compares %0d", n_errors, cmp_count);
        if (n_errors == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want)
        begin
            n_errors++;
            $display("Error at %0t: saw %h, want %h", $time, seen, want);
        end
    endtask

    // Clamped sum with carry, overflow, sign and zero
    function automatic logic [35:0] sat_add(input logic [31:0] a, b);
        logic [32:0] raw;
        logic        ov;
        logic [31:0] r;
        raw = {1'b0, a} + {1'b0, b};
        ov = (a[31] == b[31]) && (raw[31] != a[31]);
        r = ov ? (a[31] ? SAT_NEG : SAT_POS) : raw[31:0];
        return {r, raw[32], ov, r[31], r == 32'h0};
    endfunction

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1);
        check(32'(bresp), 32'(r));
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] r);
        araddr <= a;
        arvalid <= 1'b1;
        do
        begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1);
        check(rdata, d);
        check(32'(rresp), 32'(r));
    endtask

    task automatic ld(input logic [4:0] i, input logic [31:0] v);
        wr(OFF_GPR_SEL, 32'(i), RESP_OKAY);
        wr(OFF_GPR_DATA, v, RESP_OKAY);
        gpr[i] = v;
    endtask

    // Offer one add and note its expected outcome
    task automatic op(input logic f, input logic [4:0] s, d, m);
        logic [35:0] x;
        x = sat_add(gpr[d], f ? {{27{m[4]}}, m} : gpr[s]);
        if (d == 5'h0)
            sts_exp[1] = 1'b1;
        else
        begin
            sat_exp = sat_exp | x[2];
            sts_exp[0] = sts_exp[0] | x[2];
            exp_q.push_back({x, sat_exp});
            gpr[d] = x[35:4];
            n_ops++;
        end
        go <= 1'b1;
        form <= f;
        src <= s;
        dst <= d;
        imm <= m;
        @(posedge aclk);
    endtask

    task automatic flush();
        go <= 1'b0;
        repeat (3) @(posedge aclk);
    endtask

    // Compare each result pulse with the oldest expectation
    always @(posedge aclk)
        if (result_valid === 1'b1)
        begin
            e = exp_q.size() > 0 ? exp_q.pop_front() : 'x;
            check(result_data, e[36:5]); // Sum
            check(32'(flg[4:1]), 32'(e[4:1])); // Flags
            check(32'(flg[0]), 32'(e[0])); // Sticky
        end

    // Cut a hung run short
    always @(posedge aclk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_errors++;
            end_sim();
        end
    end

    // Main sequence
    initial
    begin
        seed = 32'h6551004f;
        {aresetn, awvalid, wvalid, arvalid, go, form, sat_exp} = '0;
        {awaddr, araddr, wdata, src, dst, imm, sts_exp} = '0;
        foreach (gpr[i]) gpr[i] = '0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rdc(OFF_PSW, 32'(PSW_RST), RESP_OKAY);
        check(32'(instr_ready), 32'h1); // Always ready
        mask = 2'h1;
        wr(OFF_IRQ_MASK, 32'(mask), RESP_OKAY);
        rdc(OFF_IRQ_MASK, 32'(mask), RESP_OKAY);
        foreach (VA[i])
        begin
            ld(4, VA[i]);
            ld(5, VB[i]);
            op(SAU_FORM_REG, 5, 4, 0);
            flush();
            rdc(OFF_GPR_DATA, VB[i], RESP_OKAY); // Source kept
            wr(OFF_GPR_SEL, 32'h4, RESP_OKAY);
            rdc(OFF_GPR_DATA, gpr[4], RESP_OKAY); // Written back
        end
        check(32'(irq), 32'(|(sts_exp & mask)));
        wr(OFF_IRQ_STS, 32'h1, RESP_OKAY);
        check(32'(irq), 32'h0);
        wr(OFF_PSW, 32'h0, RESP_OKAY);
        sat_exp = 1'b0;
        check(32'(flg), 32'h0); // Load clears
        op(SAU_FORM_REG, 5, 0, 0);
        flush();
        rdc(OFF_IRQ_STS, 32'h2, RESP_OKAY);
        check(32'(irq), 32'h0);
        mask = 2'h3;
        wr(OFF_IRQ_MASK, 32'(mask), RESP_OKAY);
        check(32'(irq), 32'h1);
        wr(OFF_IRQ_STS, 32'h2, RESP_OKAY);
        sts_exp = 2'h0;
        check(32'(irq), 32'h0);
        // Every immediate code, back to back
        ld(6, 32'h7FFFFFF0);
        ld(7, 32'h80000005);
        for (int i = 0; i < 32; i++)
            op(SAU_FORM_IMM, 5'($random(seed)), 6, 5'(i));
        op(SAU_FORM_IMM, 0, 7, 5'h10);
        flush();
        // Random register-form traffic
        for (int i = 1; i < 8; i++)
            ld(5'(i), $random(seed));
        for (int i = 0; i < 24; i++)
            op(SAU_FORM_REG, 5'({$random(seed)} % 8),
               5'(1 + {$random(seed)} % 7), 0);
        flush();
        rdc(OFF_OP_COUNT, 32'(n_ops), RESP_OKAY);
        rdc(8'h18, 32'h0, RESP_SLVERR);
        wr(8'h18, 32'h5, RESP_SLVERR);
        check(32'(exp_q.size()), 32'h0);
        end_sim();
    end
endmodule

`default_nettype wire
